// File: tb/rtst_timer_bench.sv
// bench: apb-driven tests of the reload timer.
// assumes the design files and rtst_defines.vh on the include path.
`timescale 1ns/1ns
`include "rtst_defines.vh"

module rtst_timer_bench;
	logic        clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic        pinA = 0, pinB = 0, err;
	logic [31:0] paddr = 0, pwdata = 0, rd;
	wire  [31:0] prdata;
	wire         pready, pslverr, outA, oeA, outF, oeF, irq, sleepMode, wakeup;
	int          n_errors = 0, compares = 0, nWake = 0, k;
	int          cyc [5] = '{312, 1250, 5000, 10000, 20000};

	rtst_timer #(.SLEEP_UNIT_CYCLES(8)) i_dut (
		.clock(clock), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .toggleOrExtClockPinIn(pinA),
		.toggleOrExtClockPinOut(outA), .toggleOrExtClockPinOe(oeA),
		.togglePinFirstOut(outF), .togglePinFirstOe(oeF),
		.altExtClockPinIn(pinB), .irq(irq), .sleepMode(sleepMode),
		.wakeup(wakeup)
	);

	// ----------------------------------------------------------------
	// clock, watchdog, wake counter
	// ----------------------------------------------------------------
	always #20 clock = ~clock;
	always @(posedge clock) begin
		if (wakeup === 1'b1)
			nWake <= nWake + 1;
	end
	initial begin
		repeat (60000) @(posedge clock);
		n_errors++;
		report_and_stop;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task report_and_stop;
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; read data and error taken at the ready edge
	// returns at the falling edge, so outputs are settled for checks
	task apb(input logic [4:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {27'h0, a};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clock);
	endtask

	task rdchk(input logic [4:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask

	// n rising edges on pin b (1) or pin a (0)
	task pulse(input logic b, input int n);
		repeat (n) begin
			@(posedge clock);
			pinA <= ~b;
			pinB <= b;
			repeat (4) @(posedge clock);
			pinA <= 1'b0;
			pinB <= 1'b0;
			repeat (4) @(posedge clock);
		end
	endtask

	task check_defaults;
		rdchk(`RTST_OFF_CTRL, {25'h0, `RTST_RST_CTRL});
		for (int i = 4; i <= 24; i += 4)
			rdchk(i[4:0], 32'h0);
	endtask

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		check_defaults;
		pulse(0, 2);
		rdchk(`RTST_OFF_COUNT, 32'h0);
		chk({29'h0, oeF, oeA, outF}, 32'h0);
		apb(5'h1c, 1'b0, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(`RTST_OFF_PRESET, 1'b1, 32'hfd);
		apb(`RTST_OFF_COUNT, 1'b1, 32'h0);
		apb(`RTST_OFF_INTEN, 1'b1, 32'h1);
		apb(`RTST_OFF_CTRL, 1'b1, 32'h6b);
		pulse(0, 2);
		rdchk(`RTST_OFF_COUNT, 32'hff);
		rdchk(`RTST_OFF_COUNT, 32'hff);
		pulse(0, 1);
		rdchk(`RTST_OFF_COUNT, 32'hfd);
		chk({28'h0, irq, outF, oeF, oeA}, 32'he);
		chk(nWake, 32'h1);
		rdchk(`RTST_OFF_STATUS, 32'h2);
		rdchk(`RTST_OFF_INTSTAT, 32'h1);
		apb(`RTST_OFF_INTSTAT, 1'b1, 32'h1);
		apb(`RTST_OFF_INTEN, 1'b1, 32'h0);
		chk({31'h0, irq}, 32'h0);
		pulse(0, 3);
		rdchk(`RTST_OFF_INTSTAT, 32'h1);
		chk({30'h0, irq, outF}, 32'h0);
		apb(`RTST_OFF_INTEN, 1'b1, 32'h1);
		chk({31'h0, irq}, 32'h1);
		apb(`RTST_OFF_INTSTAT, 1'b1, 32'h1);
		chk({31'h0, irq}, 32'h0);
		apb(`RTST_OFF_CTRL, 1'b1, 32'h3d);
		pulse(1, 3);
		rdchk(`RTST_OFF_COUNT, 32'hfd);
		chk({29'h0, outA, oeA, oeF}, 32'h6);
		apb(`RTST_OFF_INTSTAT, 1'b1, 32'h1);
		apb(`RTST_OFF_PRESET, 1'b1, 32'h0);
		// each internal rate gives about 100 ticks in its window
		for (int s = 0; s < 5; s++) begin
			apb(`RTST_OFF_CTRL, 1'b1, 32'h0e);
			apb(`RTST_OFF_COUNT, 1'b1, 32'h0);
			apb(`RTST_OFF_CTRL, 1'b1, {28'h0, s[2:0], 1'b1});
			repeat (cyc[s]) @(posedge clock);
			apb(`RTST_OFF_COUNT, 1'b0, 32'h0);
			chk({31'h0, rd > 96 && rd < 104}, 32'h1);
		end
		apb(`RTST_OFF_CTRL, 1'b1, 32'h0e);
		apb(`RTST_OFF_INTEN, 1'b1, 32'h6);
		apb(`RTST_OFF_SLEEP, 1'b1, 32'h3);
		// sleep level looked at on falling edges, where it is settled
		k = 0;
		while (sleepMode !== 1'b1 && k < 100) begin
			@(negedge clock);
			k++;
		end
		k = 0;
		while (sleepMode === 1'b1 && k < 100) begin
			@(negedge clock);
			k++;
		end
		chk(k, 32'd16);
		rdchk(`RTST_OFF_INTSTAT, 32'h6);
		chk({31'h0, irq}, 32'h1);
		apb(`RTST_OFF_PRESET, 1'b1, 32'h5a);
		apb(`RTST_OFF_CTRL, 1'b1, 32'h2b);
		@(posedge clock);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		check_defaults;
		chk({29'h0, irq, oeF, sleepMode}, 32'h0);
		report_and_stop;
	end
endmodule

// File: tb/rtst_timer_checker.sv
// checker: port-level properties of the reload timer.
// assumes one clock domain, bound onto rtst_timer below.
`timescale 1ns/1ns

module rtst_timer_checker #(
	parameter integer SLEEP_UNIT_CYCLES = 8
) (
	input wire        clock,
	input wire        srst,
	input wire        psel,
	input wire        penable,
	input wire [31:0] paddr,
	input wire [31:0] prdata,
	input wire        pslverr,
	input wire        irq,
	input wire        sleepMode,
	input wire        wakeup,
	input wire        togglePinFirstOut,
	input wire        togglePinFirstOe,
	input wire        toggleOrExtClockPinOut,
	input wire        toggleOrExtClockPinOe
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	property p_rst_quiet;
		$fell(srst) |-> !irq && !sleepMode && !togglePinFirstOe
			&& !toggleOrExtClockPinOe && !togglePinFirstOut && prdata == 32'h0;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("outputs not at rest after reset");

	property p_oe_excl;
		!(togglePinFirstOe && toggleOrExtClockPinOe);
	endproperty
	a_oe_excl: assert property (p_oe_excl)
		else $error("toggle driven on both pins");

	property p_toggle_pair;
		togglePinFirstOut == toggleOrExtClockPinOut;
	endproperty
	a_toggle_pair: assert property (p_toggle_pair)
		else $error("toggle copies differ");

	property p_prdata_hold;
		psel && penable |=> $stable(prdata);
	endproperty
	a_prdata_hold: assert property (p_prdata_hold)
		else $error("read data moved after access");

	property p_irq_fall;
		$fell(irq) |-> $past(psel && penable);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt dropped without a write");

	property p_wake_pulse;
		wakeup |=> !wakeup;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wakeup longer than one cycle");

	property p_sleep_len;
		$rose(sleepMode) |-> sleepMode [*8];
	endproperty
	a_sleep_len: assert property (p_sleep_len)
		else $error("sleep phase too short");

	property p_err_unmapped;
		psel && penable && paddr == 32'h1c |-> pslverr;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped)
		else $error("unmapped access not refused");

	property p_err_access;
		pslverr |-> psel && penable;
	endproperty
	a_err_access: assert property (p_err_access)
		else $error("error outside access phase");

	property p_toggle_step;
		$changed(togglePinFirstOut) |=> $stable(togglePinFirstOut);
	endproperty
	a_toggle_step: assert property (p_toggle_step)
		else $error("toggle flipped on two cycles in a row");
endmodule

bind rtst_timer rtst_timer_checker #(
	.SLEEP_UNIT_CYCLES(SLEEP_UNIT_CYCLES)
) i_chk (
	.clock(clock), .srst(srst), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pslverr(pslverr), .irq(irq),
	.sleepMode(sleepMode), .wakeup(wakeup),
	.togglePinFirstOut(togglePinFirstOut),
	.togglePinFirstOe(togglePinFirstOe),
	.toggleOrExtClockPinOut(toggleOrExtClockPinOut),
	.toggleOrExtClockPinOe(toggleOrExtClockPinOe)
);

// File: verilog/rtst_defines.vh
// constants for the reload timer with sleep tick: register map,
// field positions, reset values and timing figures.
// assumes inclusion by bare name from the timer design files.
`ifndef RTST_DEFINES_VH
`define RTST_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define RTST_OFF_CTRL      5'h00
`define RTST_OFF_PRESET    5'h04
`define RTST_OFF_COUNT     5'h08
`define RTST_OFF_INTSTAT   5'h0c
`define RTST_OFF_INTEN     5'h10
`define RTST_OFF_SLEEP     5'h14
`define RTST_OFF_STATUS    5'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RTST_CTRL_RUN      0
`define RTST_CTRL_SEL_LO   1
`define RTST_CTRL_SEL_HI   3
`define RTST_CTRL_ROUTE    4
`define RTST_CTRL_TOGEN    5
`define RTST_CTRL_WAKEEN   6
`define RTST_INT_OVF       0
`define RTST_INT_SLEEP     1
`define RTST_INT_WAKE      2
`define RTST_SLP_EN        0
`define RTST_SLP_N_LO      1
`define RTST_SLP_N_HI      6

// ----------------------------------------------------------------
// clock source select codes
// ----------------------------------------------------------------
`define RTST_SEL_8M        3'h0
`define RTST_SEL_2M        3'h1
`define RTST_SEL_500K      3'h2
`define RTST_SEL_250K      3'h3
`define RTST_SEL_125K      3'h4
`define RTST_SEL_EXT_A     3'h5
`define RTST_SEL_EXT_B     3'h6
`define RTST_SEL_NONE      3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RTST_RST_CTRL      7'h0e
`define RTST_RST_BYTE      8'h00
`define RTST_RST_INT       3'h0
`define RTST_RST_SLEEP     7'h00

// ----------------------------------------------------------------
// timing: system clock and tick rates in kHz
// ----------------------------------------------------------------
`define RTST_SYS_KHZ       16'd25000
`define RTST_RATE_8M       16'd8000
`define RTST_RATE_2M       16'd2000
`define RTST_RATE_500K     16'd500
`define RTST_RATE_250K     16'd250
`define RTST_RATE_125K     16'd125

// sleep interval unit in picoseconds and the clock period
`define RTST_SLEEP_UNIT_PS 976562500
`define RTST_CLK_PERIOD_PS 40000
`define RTST_SLEEP_UNIT_CYCLES (`RTST_SLEEP_UNIT_PS / `RTST_CLK_PERIOD_PS)

`endif

// File: verilog/rtst_edge_sync.v
// two-stage synchroniser with rising-edge pulse for one pin input.
// assumes a free-running system clock and synchronous active-high reset.
`timescale 1ns/1ns

module rtst_edge_sync (
	input  wire clock,
	input  wire srst,
	input  wire pinIn,
	output reg  risePulse
);

	reg stageA;
	reg stageB;
	reg stageC;

	// ----------------------------------------------------------------
	// synchroniser and edge detector
	// ----------------------------------------------------------------
	// stageA feeds stageB only; edge is taken from stageB/stageC
	always @(posedge clock) begin
		if (srst) begin
			stageA    <= 1'b0;
			stageB    <= 1'b0;
			stageC    <= 1'b0;
			risePulse <= 1'b0;
		end else begin
			stageA    <= pinIn;
			stageB    <= stageA;
			stageC    <= stageB;
			risePulse <= stageB & ~stageC;
		end
	end

endmodule

// File: verilog/rtst_timer.v
// eight-bit reloading up counter with toggle output and sleep tick,
// reached over an apb slave with sticky, maskable interrupt status.
// assumes a 25 MHz clock, synchronous srst, single-cycle apb answers.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "rtst_defines.vh"

module rtst_timer #(
	parameter integer SLEEP_UNIT_CYCLES = `RTST_SLEEP_UNIT_CYCLES
) (
	input  wire        clock,
	input  wire        srst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        toggleOrExtClockPinIn,
	output wire        toggleOrExtClockPinOut,
	output wire        toggleOrExtClockPinOe,
	output wire        togglePinFirstOut,
	output wire        togglePinFirstOe,
	input  wire        altExtClockPinIn,
	output wire        irq,
	output reg         sleepMode,
	output wire        wakeup
);

	// ----------------------------------------------------------------
	// local constants
	// ----------------------------------------------------------------
	localparam [2:0] S_OFF    = 3'b001;
	localparam [2:0] S_AWAKE  = 3'b010;
	localparam [2:0] S_ASLEEP = 3'b100;
	// last cycle of one sleep unit, cut to the unit counter width
	localparam [31:0] UNIT_LAST_W = SLEEP_UNIT_CYCLES - 1;
	localparam [14:0] UNIT_LAST = UNIT_LAST_W[14:0];

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	reg  [6:0]  ctrl;
	reg  [7:0]  preset;
	reg  [7:0]  count;
	reg  [2:0]  intStat;
	reg  [2:0]  intEn;
	reg  [6:0]  sleepCtrl;
	reg         toggleState;
	reg  [15:0] phaseAcc;
	reg  [15:0] rate;
	reg  [16:0] phaseSum;
	reg  [15:0] next_phaseAcc;
	reg         intTick;
	reg         tick;
	reg  [2:0]  sleepState;
	reg  [14:0] unitCount;
	reg  [5:0]  unitsDone;
	reg         sleepEvt;
	reg         wakeEvt;
	reg         next_sleepEvt;
	reg         next_wakeEvt;
	wire        extRiseA;
	wire        extRiseB;
	wire [2:0]  srcSel;
	wire        running;
	wire        wrap;
	wire        apbSetup;
	wire        apbWrite;
	wire        addrHit;
	wire [2:0]  evtNow;
	wire [5:0]  sleepN;
	wire        wrCtrl;
	wire        wrPreset;
	wire        wrCount;
	wire        wrIntStat;
	wire        wrIntEn;
	wire        wrSleep;

	// fields of the control and sleep registers
	assign srcSel  = ctrl[`RTST_CTRL_SEL_HI:`RTST_CTRL_SEL_LO];
	assign running = ctrl[`RTST_CTRL_RUN];
	assign sleepN  = sleepCtrl[`RTST_SLP_N_HI:`RTST_SLP_N_LO];

	// ----------------------------------------------------------------
	// external clock pins
	// ----------------------------------------------------------------
	// each pin is synchronised and reduced to a rising-edge pulse
	rtst_edge_sync uSyncA (
		.clock     (clock),
		.srst      (srst),
		.pinIn     (toggleOrExtClockPinIn),
		.risePulse (extRiseA)
	);

	rtst_edge_sync uSyncB (
		.clock     (clock),
		.srst      (srst),
		.pinIn     (altExtClockPinIn),
		.risePulse (extRiseB)
	);

	// ----------------------------------------------------------------
	// internal tick generation
	// ----------------------------------------------------------------
	// rate table for the internal sources, in kHz
	always @* begin
		case (srcSel)
			`RTST_SEL_8M:   rate = `RTST_RATE_8M;
			`RTST_SEL_2M:   rate = `RTST_RATE_2M;
			`RTST_SEL_500K: rate = `RTST_RATE_500K;
			`RTST_SEL_250K: rate = `RTST_RATE_250K;
			`RTST_SEL_125K: rate = `RTST_RATE_125K;
			default:        rate = 16'h0000;
		endcase
	end

	// fractional accumulator: mean tick rate equals rate exactly
	always @* begin
		phaseSum = {1'b0, phaseAcc} + {1'b0, rate};
		if (phaseSum >= {1'b0, `RTST_SYS_KHZ}) begin
			next_phaseAcc = phaseSum[15:0] - `RTST_SYS_KHZ;
			intTick       = 1'b1;
		end else begin
			next_phaseAcc = phaseSum[15:0];
			intTick       = 1'b0;
		end
	end

	// accumulator only advances while the counter runs
	always @(posedge clock) begin
		if (srst || !running) begin
			phaseAcc <= 16'h0000;
		end else begin
			phaseAcc <= next_phaseAcc;
		end
	end

	// select the tick that feeds the counter
	always @* begin
		case (srcSel)
			`RTST_SEL_EXT_A: tick = extRiseA;
			`RTST_SEL_EXT_B: tick = extRiseB;
			default:         tick = intTick;
		endcase
	end

	// ----------------------------------------------------------------
	// counter, reload and toggle
	// ----------------------------------------------------------------
	assign wrap = running && tick && (count == 8'hff);

	// count up on ticks; a wrap reloads the preset directly
	always @(posedge clock) begin
		if (srst) begin
			count <= `RTST_RST_BYTE;
		end else if (wrCount) begin
			count <= preset;
		end else if (wrap) begin
			count <= preset;
		end else if (running && tick) begin
			count <= count + 8'h01;
		end
	end

	// toggle flips on every wrap
	always @(posedge clock) begin
		if (srst) begin
			toggleState <= 1'b0;
		end else if (wrap) begin
			toggleState <= ~toggleState;
		end
	end

	// toggle routed to one of two pins, driven only when enabled
	assign togglePinFirstOut      = toggleState;
	assign toggleOrExtClockPinOut = toggleState;
	assign togglePinFirstOe       = running && ctrl[`RTST_CTRL_TOGEN]
		&& !ctrl[`RTST_CTRL_ROUTE];
	assign toggleOrExtClockPinOe  = running && ctrl[`RTST_CTRL_TOGEN]
		&& ctrl[`RTST_CTRL_ROUTE]
		&& srcSel != `RTST_SEL_EXT_A;

	// ----------------------------------------------------------------
	// sleep and wake interval timer
	// ----------------------------------------------------------------
	// alternates awake and asleep phases of (n+1) units each
	always @* begin
		next_sleepEvt = 1'b0;
		next_wakeEvt  = 1'b0;
		if (unitCount == UNIT_LAST && unitsDone >= sleepN) begin
			next_sleepEvt = sleepState == S_AWAKE;
			next_wakeEvt  = sleepState == S_ASLEEP;
		end
	end

	// unit and phase counters; a shrunk n ends the phase at the end of the current unit
	always @(posedge clock) begin
		if (srst) begin
			sleepState <= S_OFF;
			unitCount  <= 15'h0000;
			unitsDone  <= 6'h00;
			sleepMode  <= 1'b0;
			sleepEvt   <= 1'b0;
			wakeEvt    <= 1'b0;
		end else begin
			sleepEvt <= next_sleepEvt;
			wakeEvt  <= next_wakeEvt;
			case (sleepState)
				S_OFF: begin
					unitCount <= 15'h0000;
					unitsDone <= 6'h00;
					sleepMode <= 1'b0;
					if (sleepCtrl[`RTST_SLP_EN]) begin
						sleepState <= S_AWAKE;
					end
				end
				S_AWAKE, S_ASLEEP: begin
					if (!sleepCtrl[`RTST_SLP_EN]) begin
						sleepState <= S_OFF;
					end else if (unitCount != UNIT_LAST) begin
						unitCount <= unitCount + 15'h0001;
					end else if (unitsDone < sleepN) begin
						unitCount <= 15'h0000;
						unitsDone <= unitsDone + 6'h01;
					end else begin
						unitCount  <= 15'h0000;
						unitsDone  <= 6'h00;
						sleepMode  <= sleepState == S_AWAKE;
						sleepState <= (sleepState == S_AWAKE)
							? S_ASLEEP : S_AWAKE;
					end
				end
				default: begin
					sleepState <= S_OFF;
				end
			endcase
		end
	end

	// wake on the interval or on an enabled overflow
	assign wakeup = wakeEvt
		|| (wrap && ctrl[`RTST_CTRL_WAKEEN]);

	// ----------------------------------------------------------------
	// interrupt status and request
	// ----------------------------------------------------------------
	// events that set the sticky status bits
	assign evtNow = {wakeEvt, sleepEvt, wrap};

	// sticky bits, write one to clear; a new event beats the clear
	always @(posedge clock) begin
		if (srst) begin
			intStat <= `RTST_RST_INT;
		end else if (wrIntStat) begin
			intStat <= (intStat & ~pwdata[2:0]) | evtNow;
		end else begin
			intStat <= intStat | evtNow;
		end
	end

	// request rises in the wrap cycle itself when enabled
	assign irq = |(intStat & intEn)
		|| (wrap && intEn[`RTST_INT_OVF]);

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign apbSetup = psel && !penable;
	assign apbWrite = psel && penable && pwrite && !pslverr;
	assign addrHit  = paddr[31:5] == 27'h0 && paddr[1:0] == 2'h0
		&& paddr[4:2] != 3'h7;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !addrHit;

	// ----------------------------------------------------------------
	// register write strobes
	// ----------------------------------------------------------------
	// one strobe per writable register, access phase only
	assign wrCtrl    = apbWrite && paddr[4:0] == `RTST_OFF_CTRL;
	assign wrPreset  = apbWrite && paddr[4:0] == `RTST_OFF_PRESET;
	assign wrCount   = apbWrite && paddr[4:0] == `RTST_OFF_COUNT;
	assign wrIntStat = apbWrite && paddr[4:0] == `RTST_OFF_INTSTAT;
	assign wrIntEn   = apbWrite && paddr[4:0] == `RTST_OFF_INTEN;
	assign wrSleep   = apbWrite && paddr[4:0] == `RTST_OFF_SLEEP;

	// software-written registers
	always @(posedge clock) begin
		if (srst) begin
			ctrl      <= `RTST_RST_CTRL;
			preset    <= `RTST_RST_BYTE;
			intEn     <= `RTST_RST_INT;
			sleepCtrl <= `RTST_RST_SLEEP;
		end else begin
			if (wrCtrl) begin
				ctrl <= pwdata[6:0];
			end
			if (wrPreset) begin
				preset <= pwdata[7:0];
			end
			if (wrIntEn) begin
				intEn <= pwdata[2:0];
			end
			if (wrSleep) begin
				sleepCtrl <= pwdata[6:0];
			end
		end
	end

	// read data captured in the setup cycle; reading has no side effect
	always @(posedge clock) begin
		if (srst) begin
			prdata <= 32'h00000000;
		end else if (apbSetup) begin
			case (paddr[4:0])
				`RTST_OFF_CTRL:    prdata <= {25'h0, ctrl};
				`RTST_OFF_PRESET:  prdata <= {24'h0, preset};
				`RTST_OFF_COUNT:   prdata <= {24'h0, count};
				`RTST_OFF_INTSTAT: prdata <= {29'h0, intStat};
				`RTST_OFF_INTEN:   prdata <= {29'h0, intEn};
				`RTST_OFF_SLEEP:   prdata <= {25'h0, sleepCtrl};
				`RTST_OFF_STATUS:  prdata <= {30'h0,
					toggleState, sleepMode};
				default:           prdata <= 32'h00000000;
			endcase
		end
	end

endmodule
